// ### include/pps_map.vh
// Constants for the push-pull fault and mode sequencer
`ifndef PPS_MAP_VH
`define PPS_MAP_VH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PPS_CLK_PERIOD_NS   20
`define PPS_OV_DELAY_NS     550
`define PPS_HICCUP_NS       100
`define PPS_HARD_RESP_NS    65
`define PPS_HARD_PERSIST_US 200
`define PPS_GLITCH_US       5
`define PPS_DEAD_NS         70
`define PPS_OSC_HALF_CYC    25
`define PPS_SS_STEP_CYC     16
`define PPS_EXT_TIMEOUT_CYC 500
// ------------------------------------------------------------
// Thresholds and field positions
// ------------------------------------------------------------
`define PPS_HARD_MA         5000
`define PPS_DIP_MV          2500
`define PPS_GATE_FULL       8'hFF
`define PPS_IN_TURN_ON      0
`define PPS_IN_SUPPLY_LOCK  1
`define PPS_IN_SUPPLY_MIN   2
`define PPS_IN_OV_RISE      3
`define PPS_IN_OV_FALL      4
`define PPS_IN_HOT          5
`define PPS_IN_COOL         6
`define PPS_IN_EXT_CLK      7
`define PPS_ST_SHUT         3'h0
`define PPS_ST_WAIT         3'h1
`define PPS_ST_SOFT         3'h2
`define PPS_ST_RUN          3'h3
`define PPS_ST_DISCH        3'h4
`endif

// ### rtl/pps_sequencer.v
// Protection and mode sequencing for a push-pull transformer driver
`timescale 1ns/1ps
`default_nettype none
`include "pps_map.vh"
module pps_sequencer #(
  parameter [15:0] HARD_SHORT_CYC  = (`PPS_HARD_PERSIST_US * 1000) / `PPS_CLK_PERIOD_NS,
  parameter [15:0] OSC_HALF_CYC    = `PPS_OSC_HALF_CYC,
  parameter [15:0] SS_STEP_CYC     = `PPS_SS_STEP_CYC,
  parameter [15:0] EXT_TIMEOUT_CYC = `PPS_EXT_TIMEOUT_CYC
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        TURN_ON_SENSE,
  input  wire        SUPPLY_ABOVE_LOCKOUT,
  input  wire        SUPPLY_ABOVE_MIN,
  input  wire        OV_ABOVE_RISE,
  input  wire        OV_BELOW_FALL,
  input  wire        THERM_ABOVE_TRIP,
  input  wire        THERM_BELOW_CLEAR,
  input  wire        EXT_CLK,
  input  wire [12:0] CURRENT_ONE,
  input  wire [12:0] CURRENT_TWO,
  input  wire [11:0] CURRENT_THRESHOLD,
  input  wire [11:0] LIMIT_PIN_DIP,
  output reg         DRIVE_ONE,
  output reg         DRIVE_TWO,
  output reg         DRAIN_ONE_OE,
  output reg         DRAIN_TWO_OE,
  output reg  [7:0]  GATE_STRENGTH,
  output reg  [2:0]  MODE,
  output reg         SYNC_ACTIVE,
  output reg         DUTY_SPREAD_ALLOWED
);

  // ------------------------------------------------------------
  // Derived cycle counts
  // ------------------------------------------------------------
  // Longest times round down, least times round up
  localparam [15:0] OV_CYC     = `PPS_OV_DELAY_NS / `PPS_CLK_PERIOD_NS;
  localparam [15:0] HICCUP_CYC = (`PPS_HICCUP_NS + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS;
  localparam [15:0] GLITCH_CYC = (`PPS_GLITCH_US * 1000) / `PPS_CLK_PERIOD_NS;
  localparam [15:0] DEAD_CYC   = (`PPS_DEAD_NS + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS;
  localparam [12:0] HARD_MA    = `PPS_HARD_MA;
  localparam [11:0] DIP_MV     = `PPS_DIP_MV;
  localparam [7:0]  GATE_FULL  = `PPS_GATE_FULL;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  wire [7:0] raw_in;
  reg  [7:0] sync_a;
  reg  [7:0] sync_b;

  assign raw_in = {EXT_CLK, THERM_BELOW_CLEAR, THERM_ABOVE_TRIP, OV_BELOW_FALL,
                   OV_ABOVE_RISE, SUPPLY_ABOVE_MIN, SUPPLY_ABOVE_LOCKOUT, TURN_ON_SENSE};

  // Two stages; reset to zero so an unknown turn-on level reads as off
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  wire supply_ok  = sync_b[`PPS_IN_SUPPLY_LOCK];
  wire supply_min = sync_b[`PPS_IN_SUPPLY_MIN];

  // ------------------------------------------------------------
  // Turn-on glitch filter
  // ------------------------------------------------------------
  reg        en_filt;
  reg [15:0] glitch_cnt;

  // Level must stay changed for the whole interval before it is taken
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      en_filt    <= 1'b0;
      glitch_cnt <= 16'h0000;
    end else if (sync_b[`PPS_IN_TURN_ON] == en_filt) begin
      glitch_cnt <= 16'h0000;
    end else if (glitch_cnt == GLITCH_CYC - 16'h0001) begin
      en_filt    <= sync_b[`PPS_IN_TURN_ON];
      glitch_cnt <= 16'h0000;
    end else begin
      glitch_cnt <= glitch_cnt + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Overvoltage and thermal latches
  // ------------------------------------------------------------
  reg        ov_stop;
  reg [15:0] ov_cnt;
  reg        therm_stop;

  // The stop is taken only after the level persists for the response delay
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ov_stop <= 1'b0;
      ov_cnt  <= 16'h0000;
    end else begin
      if (!sync_b[`PPS_IN_OV_RISE]) begin
        ov_cnt <= 16'h0000;
      end else if (ov_cnt != OV_CYC) begin
        ov_cnt <= ov_cnt + 16'h0001;
      end
      if (sync_b[`PPS_IN_OV_RISE] && ov_cnt == OV_CYC - 16'h0001) begin
        ov_stop <= 1'b1;
      end else if (sync_b[`PPS_IN_OV_FALL] && !sync_b[`PPS_IN_OV_RISE]) begin
        ov_stop <= 1'b0;
      end
    end
  end

  // Set wins over clear so a fresh trip is never dropped
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      therm_stop <= 1'b0;
    end else if (sync_b[`PPS_IN_HOT]) begin
      therm_stop <= 1'b1;
    end else if (sync_b[`PPS_IN_COOL]) begin
      therm_stop <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // External clock detection and sync mode
  // ------------------------------------------------------------
  reg        ext_prev;
  reg        sync_mode;
  reg        clock_lost;
  reg [15:0] ext_timer;
  wire       ext_rise = sync_b[`PPS_IN_EXT_CLK] & ~ext_prev;

  // Sync mode is sticky; only a reset brings the oscillator back
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ext_prev   <= 1'b0;
      sync_mode  <= 1'b0;
      clock_lost <= 1'b0;
      ext_timer  <= 16'h0000;
    end else begin
      ext_prev <= sync_b[`PPS_IN_EXT_CLK];
      if (ext_rise) begin
        sync_mode <= 1'b1;
        ext_timer <= 16'h0000;
      end else if (sync_mode && ext_timer != EXT_TIMEOUT_CYC) begin
        ext_timer <= ext_timer + 16'h0001;
      end
      if (sync_mode && ext_timer == EXT_TIMEOUT_CYC - 16'h0001 && !ext_rise) begin
        clock_lost <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Current comparison per switch
  // ------------------------------------------------------------
  wire [1:0]  trip;
  wire [1:0]  hard_over;
  wire [25:0] cur_pair = {CURRENT_TWO, CURRENT_ONE};
  wire        dip_large = (LIMIT_PIN_DIP >= DIP_MV);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sense
      assign trip[gi]      = (cur_pair[gi*13 +: 13] >= {1'b0, CURRENT_THRESHOLD});
      assign hard_over[gi] = (cur_pair[gi*13 +: 13] >= HARD_MA) || (trip[gi] && dip_large);
    end
  endgenerate

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg        hard_flag;
  reg [15:0] hard_cnt;
  reg [7:0]  gate;
  reg [15:0] ss_cnt;
  wire       hard_timeout = hard_flag && (hard_cnt == HARD_SHORT_CYC - 16'h0001);
  wire       switching_state = (state == `PPS_ST_SOFT) || (state == `PPS_ST_RUN);

  always @* begin
    next_state = state;
    case (state)
      `PPS_ST_SHUT: begin
        if (en_filt) next_state = `PPS_ST_WAIT;
      end
      `PPS_ST_WAIT: begin
        if (supply_ok && supply_min) next_state = `PPS_ST_SOFT;
      end
      `PPS_ST_SOFT: begin
        if (!supply_ok) next_state = `PPS_ST_WAIT;
        else if (hard_timeout) next_state = `PPS_ST_DISCH;
        else if (gate == GATE_FULL) next_state = `PPS_ST_RUN;
      end
      `PPS_ST_RUN: begin
        if (!supply_ok) next_state = `PPS_ST_WAIT;
        else if (hard_timeout) next_state = `PPS_ST_DISCH;
      end
      `PPS_ST_DISCH: begin
        if (gate == 8'h00 && !hard_flag) next_state = `PPS_ST_SOFT;
      end
      default: next_state = `PPS_ST_SHUT;
    endcase
    if (!en_filt) next_state = `PPS_ST_SHUT;
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= `PPS_ST_SHUT;
    end else begin
      state <= next_state;
    end
  end

  // Hard short is registered once, keeping the cut inside the response time
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hard_flag <= 1'b0;
      hard_cnt  <= 16'h0000;
    end else begin
      hard_flag <= (switching_state || state == `PPS_ST_DISCH) && (|hard_over);
      if (!hard_flag) begin
        hard_cnt <= 16'h0000;
      end else if (hard_cnt != HARD_SHORT_CYC) begin
        hard_cnt <= hard_cnt + 16'h0001;
      end
    end
  end

  // Gate strength ramps up in soft-start and drains fully after a hard short
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      gate   <= 8'h00;
      ss_cnt <= 16'h0000;
    end else begin
      case (state)
        `PPS_ST_SOFT: begin
          if (ss_cnt == SS_STEP_CYC - 16'h0001) begin
            ss_cnt <= 16'h0000;
            if (gate != GATE_FULL) gate <= gate + 8'h01;
          end else begin
            ss_cnt <= ss_cnt + 16'h0001;
          end
        end
        `PPS_ST_RUN: begin
          gate   <= GATE_FULL;
          ss_cnt <= 16'h0000;
        end
        `PPS_ST_DISCH: begin
          if (gate != 8'h00) gate <= gate - 8'h01;
          ss_cnt <= 16'h0000;
        end
        default: begin
          gate   <= 8'h00;
          ss_cnt <= 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Phase, dead time and hiccup
  // ------------------------------------------------------------
  reg        phase;
  reg [15:0] osc_cnt;
  reg [15:0] dead_cnt;
  reg [15:0] hic_cnt;
  wire       osc_tick = (osc_cnt == OSC_HALF_CYC - 16'h0001);
  wire       phase_tick = sync_mode ? ext_rise : osc_tick;
  wire       guard_on = (state == `PPS_ST_RUN);
  wire       soft_trip = guard_on && (|trip) && !dip_large;

  // Each external rising edge flips the phase, so each switch runs at half its rate
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase    <= 1'b0;
      osc_cnt  <= 16'h0000;
      dead_cnt <= DEAD_CYC;
      hic_cnt  <= 16'h0000;
    end else begin
      osc_cnt <= (osc_tick || sync_mode) ? 16'h0000 : osc_cnt + 16'h0001;
      if (phase_tick) begin
        phase    <= ~phase;
        dead_cnt <= DEAD_CYC;
      end else if (dead_cnt != 16'h0000) begin
        dead_cnt <= dead_cnt - 16'h0001;
      end
      if (soft_trip) begin
        hic_cnt <= HICCUP_CYC;
      end else if (hic_cnt != 16'h0000) begin
        hic_cnt <= hic_cnt - 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  // Every fault but the soft current trip funnels into one inhibit so neither drive can miss one
  wire inhibit = ov_stop | therm_stop | hard_flag | clock_lost | !supply_ok | !supply_min;
  wire may_switch = switching_state && !inhibit && dead_cnt == 16'h0000 && hic_cnt == 16'h0000;
  wire next_drive_one = may_switch && !phase && !(guard_on && trip[0]);
  wire next_drive_two = may_switch && phase && !(guard_on && trip[1]);
  wire next_oe = en_filt && supply_min;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVE_ONE           <= 1'b0;
      DRIVE_TWO           <= 1'b0;
      DRAIN_ONE_OE        <= 1'b0;
      DRAIN_TWO_OE        <= 1'b0;
      GATE_STRENGTH       <= 8'h00;
      MODE                <= `PPS_ST_SHUT;
      SYNC_ACTIVE         <= 1'b0;
      DUTY_SPREAD_ALLOWED <= 1'b1;
    end else begin
      DRIVE_ONE           <= next_drive_one;
      DRIVE_TWO           <= next_drive_two;
      DRAIN_ONE_OE        <= next_oe;
      DRAIN_TWO_OE        <= next_oe;
      GATE_STRENGTH       <= gate;
      MODE                <= state;
      SYNC_ACTIVE         <= sync_mode;
      DUTY_SPREAD_ALLOWED <= !sync_mode;
    end
  end

endmodule
`default_nettype wire

// ### testbench/pps_checker.sv
// Checker for the push-pull fault and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pps_checker (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        SUPPLY_ABOVE_LOCKOUT,
  input wire logic        SUPPLY_ABOVE_MIN,
  input wire logic        OV_ABOVE_RISE,
  input wire logic        THERM_ABOVE_TRIP,
  input wire logic [12:0] CURRENT_ONE,
  input wire logic [11:0] CURRENT_THRESHOLD,
  input wire logic [11:0] LIMIT_PIN_DIP,
  input wire logic        DRIVE_ONE,
  input wire logic        DRIVE_TWO,
  input wire logic        DRAIN_ONE_OE,
  input wire logic        DRAIN_TWO_OE,
  input wire logic [2:0]  MODE,
  input wire logic        SYNC_ACTIVE,
  input wire logic        DUTY_SPREAD_ALLOWED
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [5:0] ov_run;
  // Saturating run length of overvoltage; too long for a repetition
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) ov_run <= 6'h00;
    else if (!OV_ABOVE_RISE) ov_run <= 6'h00;
    else if (ov_run != 6'h3F) ov_run <= ov_run + 6'h01;
  end
  property p_no_overlap;
    !(DRIVE_ONE && DRIVE_TWO);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both drives on");
  property p_dead;
    ($fell(DRIVE_ONE) || $fell(DRIVE_TWO)) |-> (!DRIVE_ONE && !DRIVE_TWO) [*4];
  endproperty
  a_dead: assert property (p_dead) else $error("dead time too short");
  property p_uv;
    (!SUPPLY_ABOVE_LOCKOUT) [*5] |-> !DRIVE_ONE && !DRIVE_TWO;
  endproperty
  a_uv: assert property (p_uv) else $error("drive under lockout");
  property p_oe;
    (!SUPPLY_ABOVE_MIN) [*6] |-> !DRAIN_ONE_OE && !DRAIN_TWO_OE;
  endproperty
  a_oe: assert property (p_oe) else $error("drain enabled at low supply");
  property p_hot;
    THERM_ABOVE_TRIP [*5] |-> !DRIVE_ONE && !DRIVE_TWO;
  endproperty
  a_hot: assert property (p_hot) else $error("drive while hot");
  property p_ov;
    ov_run >= 6'h24 |-> !DRIVE_ONE && !DRIVE_TWO;
  endproperty
  a_ov: assert property (p_ov) else $error("drive during overvoltage");
  // Soft trip in run mode: value 3 is run
  property p_trip;
    (MODE == 3'h3 && DRIVE_ONE && CURRENT_ONE >= CURRENT_THRESHOLD
      && CURRENT_ONE < 13'h1388 && LIMIT_PIN_DIP < 12'h9C4)
      |=> (!DRIVE_ONE && !DRIVE_TWO) [*4];
  endproperty
  a_trip: assert property (p_trip) else $error("no hiccup after trip");
  property p_hard;
    (CURRENT_ONE >= 13'h1388 && (MODE == 3'h2 || MODE == 3'h3))
      |-> ##2 (!DRIVE_ONE && !DRIVE_TWO);
  endproperty
  a_hard: assert property (p_hard) else $error("hard short not cut");
  property p_sync;
    SYNC_ACTIVE |=> SYNC_ACTIVE && !DUTY_SPREAD_ALLOWED;
  endproperty
  a_sync: assert property (p_sync) else $error("sync mode left");
  c_disch: cover property (MODE == 3'h4);
  c_sync: cover property (SYNC_ACTIVE && DRIVE_TWO);
  c_run: cover property (MODE == 3'h3 && $rose(DRIVE_TWO));
endmodule
bind pps_sequencer pps_checker u_pps_checker (
  .CLOCK(CLOCK), .RST_N(RST_N), .SUPPLY_ABOVE_LOCKOUT(SUPPLY_ABOVE_LOCKOUT),
  .SUPPLY_ABOVE_MIN(SUPPLY_ABOVE_MIN), .OV_ABOVE_RISE(OV_ABOVE_RISE),
  .THERM_ABOVE_TRIP(THERM_ABOVE_TRIP), .CURRENT_ONE(CURRENT_ONE),
  .CURRENT_THRESHOLD(CURRENT_THRESHOLD), .LIMIT_PIN_DIP(LIMIT_PIN_DIP),
  .DRIVE_ONE(DRIVE_ONE), .DRIVE_TWO(DRIVE_TWO), .DRAIN_ONE_OE(DRAIN_ONE_OE),
  .DRAIN_TWO_OE(DRAIN_TWO_OE), .MODE(MODE), .SYNC_ACTIVE(SYNC_ACTIVE),
  .DUTY_SPREAD_ALLOWED(DUTY_SPREAD_ALLOWED));
`default_nettype wire

// ### testbench/pps_partner.sv
// Transformer primary and external clock source model
`timescale 1ns/1ps
`default_nettype none
module pps_partner (
  input  wire logic        clk,
  input  wire logic        drive_one,
  input  wire logic        drive_two,
  input  wire logic [11:0] load_ma,
  input  wire logic        hard_short,
  input  wire logic        clk_on,
  output var  logic        ext_clk,
  output wire logic [12:0] current_one,
  output wire logic [12:0] current_two
);
  logic [1:0] div = 2'h0;
  // A dead short pulls the fixed high figure even between pulses
  assign current_one = hard_short ? 13'h1388 : (drive_one ? {1'b0, load_ma} : 13'h0000);
  assign current_two = hard_short ? 13'h1388 : (drive_two ? {1'b0, load_ma} : 13'h0000);
  initial ext_clk = 1'b0;
  // Source stands still low until asked; period is six core cycles
  always @(negedge clk) begin
    if (!clk_on) begin
      div     <= 2'h0;
      ext_clk <= 1'b0;
    end else if (div == 2'h2) begin
      div     <= 2'h0;
      ext_clk <= !ext_clk;
    end else begin
      div <= div + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the push-pull fault and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Stimulus, instances and scenarios
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, turn_on = 1'b0, sup_lock = 1'b0, sup_min = 1'b0;
  logic ov_rise = 1'b0, ov_fall = 1'b1, hot = 1'b0, cool = 1'b1, hard_short = 1'b0;
  logic clk_on = 1'b0, ext_clk, drv_one, drv_two, oe_one, oe_two, sync_act, spread;
  logic [11:0] load_ma = 12'h12C, thr = 12'h1F4, dip = 12'h3E8;
  logic [12:0] cur_one, cur_two;
  logic [7:0] gate;
  logic [2:0] mode;
  int n_mismatch = 0, cmp_count = 0, n_on, n_rise;
  always #10 clk = !clk;
  // Short persistence count keeps the hard-short run brief
  pps_sequencer #(.HARD_SHORT_CYC(16'h0032), .SS_STEP_CYC(16'h0001)) u_pps_sequencer (
    .CLOCK(clk), .RST_N(rst_n), .TURN_ON_SENSE(turn_on), .SUPPLY_ABOVE_LOCKOUT(sup_lock),
    .SUPPLY_ABOVE_MIN(sup_min), .OV_ABOVE_RISE(ov_rise), .OV_BELOW_FALL(ov_fall),
    .THERM_ABOVE_TRIP(hot), .THERM_BELOW_CLEAR(cool), .EXT_CLK(ext_clk),
    .CURRENT_ONE(cur_one), .CURRENT_TWO(cur_two), .CURRENT_THRESHOLD(thr),
    .LIMIT_PIN_DIP(dip), .DRIVE_ONE(drv_one), .DRIVE_TWO(drv_two), .DRAIN_ONE_OE(oe_one),
    .DRAIN_TWO_OE(oe_two), .GATE_STRENGTH(gate), .MODE(mode), .SYNC_ACTIVE(sync_act),
    .DUTY_SPREAD_ALLOWED(spread));
  pps_partner u_pps_partner (.clk(clk), .drive_one(drv_one), .drive_two(drv_two),
    .load_ma(load_ma), .hard_short(hard_short), .clk_on(clk_on), .ext_clk(ext_clk),
    .current_one(cur_one), .current_two(cur_two));
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Count drive-high cycles and first-drive rises over a span
  task act(input int n);
    logic prev;
    prev = drv_one;
    n_on = 0;
    n_rise = 0;
    repeat (n) begin
      @(negedge clk);
      n_on += (drv_one === 1'b1) + (drv_two === 1'b1);
      n_rise += (drv_one === 1'b1 && prev !== 1'b1);
      prev = drv_one;
    end
  endtask
  task wait_mode(input logic [2:0] m, input int lim);
    int k;
    k = 0;
    while (mode !== m && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("mode", m, mode);
  endtask
  task t_glitch;
    turn_on = 1'b1;
    repeat (100) @(negedge clk);
    chk("glitch held off", 12'h000, mode);
    turn_on = 1'b0;
    repeat (300) @(negedge clk);
    chk("glitch mode", 12'h000, mode);
    chk("floating drains", 12'h000, oe_one | oe_two);
  endtask
  task t_start;
    turn_on = 1'b1;
    wait_mode(3'h1, 400);
    act(60);
    chk("idle drive", 12'h000, n_on);
    chk("low supply drain", 12'h000, oe_one);
    sup_lock = 1'b1;
    sup_min = 1'b1;
    wait_mode(3'h2, 20);
    repeat (30) @(negedge clk);
    chk("ramp mid", 12'h001, gate > 8'h10 && gate < 8'h40);
    wait_mode(3'h3, 300);
    chk("ramp full", 12'h0FF, gate);
    chk("drains driven", 12'h001, oe_one & oe_two);
    turn_on = 1'b0;
    act(100);
    turn_on = 1'b1;
    chk("filtered drop", 12'h003, mode);
    chk("run drive", 12'h001, n_on > 60);
  endtask
  // Overvoltage or heat halts switching until its clear level returns
  task t_stop(input bit ov);
    ov_rise = ov;
    hot = !ov;
    ov_fall = !ov;
    cool = ov;
    if (ov) begin
      act(20);
      chk("still on", 12'h001, n_on > 0);
    end
    repeat (ov ? 15 : 5) @(negedge clk);
    act(40);
    chk("halted", 12'h000, n_on);
    ov_rise = 1'b0;
    hot = 1'b0;
    act(60);
    chk("held", 12'h000, n_on);
    ov_fall = 1'b1;
    cool = 1'b1;
    act(60);
    chk("resumed", 12'h001, n_on > 0);
  endtask
  task t_hard;
    int k;
    load_ma = 12'h2BC;
    act(100);
    chk("hiccup", 12'h001, n_on > 0 && n_on < 40);
    load_ma = 12'h12C;
    act(100);
    chk("below limit", 12'h001, n_on > 60);
    hard_short = 1'b1;
    repeat (3) @(negedge clk);
    act(20);
    chk("hard off", 12'h000, n_on);
    wait_mode(3'h4, 100);
    k = 0;
    while (gate !== 8'h00 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("discharged", 12'h000, gate);
    hard_short = 1'b0;
    load_ma = 12'h2BC;
    wait_mode(3'h2, 20);
    act(100);
    chk("guard idle", 12'h001, n_on > 60);
    wait_mode(3'h3, 300);
    act(100);
    chk("guard armed", 12'h001, n_on > 0 && n_on < 40);
    load_ma = 12'h12C;
  endtask
  task t_sync;
    chk("spread before sync", 12'h001, spread);
    clk_on = 1'b1;
    repeat (20) @(negedge clk);
    chk("sync", 12'h001, sync_act);
    chk("no spread", 12'h000, spread);
    act(120);
    chk("half rate", 12'h001, n_rise >= 9 && n_rise <= 11);
    clk_on = 1'b0;
    repeat (600) @(negedge clk);
    clk_on = 1'b1;
    act(100);
    chk("stays stopped", 12'h000, n_on);
    chk("sync kept", 12'h001, sync_act);
    turn_on = 1'b0;
    wait_mode(3'h0, 400);
    chk("drains off", 12'h000, oe_one | oe_two);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_glitch;
    t_start;
    t_stop(1'b1);
    t_stop(1'b0);
    t_hard;
    t_sync;
    give_verdict;
  end
  // Whole run needs about three and a half thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
